// *** shared/csq_defines.svh ***
// Operation
// - STOP command: RUN, STOP one cycle, START.
// - soft reset pulse after all fetches done.
// - software stop or async halt via mode bits.
// - flags record STOP and async halt phases.
// - stop phase flag is write-one-to-clear.
// - interrupt raised when stop flag sets.
// - fetch active bit zero when fetches done.
// - always fetch sixteen 128-bit instructions.
// - group moves as two INCR16 64-bit bursts.
// - status reads always complete normally.
`ifndef CSQ_DEFINES_SVH
`define CSQ_DEFINES_SVH

// register byte offsets
`define CSQ_OFF_MODE 8'h00
`define CSQ_OFF_PROG_BASE 8'h04
`define CSQ_OFF_STATUS0 8'h08
`define CSQ_OFF_STATUS3 8'h0c
`define CSQ_OFF_IRQ_STATUS 8'h10
`define CSQ_OFF_IRQ_ENABLE 8'h14
`define CSQ_OFF_IRQ_CLEAR 8'h18
`define CSQ_OFF_WORK 8'h20

// decoded register selects
`define CSQ_SEL_NONE 4'h0
`define CSQ_SEL_MODE 4'h1
`define CSQ_SEL_PROG_BASE 4'h2
`define CSQ_SEL_STATUS0 4'h3
`define CSQ_SEL_STATUS3 4'h4
`define CSQ_SEL_IRQ_STATUS 4'h5
`define CSQ_SEL_IRQ_ENABLE 4'h6
`define CSQ_SEL_IRQ_CLEAR 4'h7
`define CSQ_SEL_WORK 4'h8

// mode control bits (write pulses, read as zero)
`define CSQ_MODE_RUN 0
`define CSQ_MODE_STOP 1
`define CSQ_MODE_AHALT 2

// status word 0 / interrupt bits
`define CSQ_ST0_STOP_SEEN 0
`define CSQ_ST0_AHALT_SEEN 1
`define CSQ_ST0_STATE_LSB 2

// status word 3 bits
`define CSQ_ST3_FETCH_ON 0
`define CSQ_ST3_SR_PEND 1
`define CSQ_ST3_COUNT_LSB 16

// reset values
`define CSQ_RST_PROG_BASE 32'h0000_0000
`define CSQ_RST_WORK 32'h0000_0000

// instruction fields and opcodes
`define CSQ_OP_LSB 124
`define CSQ_IDX_LSB 64
`define CSQ_OP_NOP 4'h0
`define CSQ_OP_WORK 4'h1
`define CSQ_OP_STOP 4'hf

// fetch shape
`define CSQ_BEAT_W 64
`define CSQ_BURST_LEN 16
`define CSQ_BURSTS 2
`define CSQ_GROUP_BYTES 32'h0000_0100

// axi responses
`define CSQ_RESP_OKAY 2'b00
`define CSQ_RESP_SLVERR 2'b10

`endif

// *** shared/csq_pkg.sv ***
package csq_pkg;
   typedef enum logic [1:0] {
      CSQ_START = 2'b00,
      CSQ_RUN = 2'b01,
      CSQ_STOP = 2'b11,
      CSQ_AHALT = 2'b10
   } csq_state_e;

   typedef enum logic [1:0] {
      CSQ_DMA_IDLE = 2'b00,
      CSQ_DMA_REQ = 2'b01,
      CSQ_DMA_DATA = 2'b11
   } csq_dma_state_e;

   typedef logic [31:0] csq_word_t;
endpackage : csq_pkg

// *** verilog/csq_irq.sv ***
`include "csq_defines.svh"
module csq_irq #(
   parameter int N = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [N-1:0] event_set,
   input wire logic clr_we,
   input wire logic [N-1:0] clr_bits,
   input wire logic en_we,
   input wire logic [N-1:0] en_bits,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic irq
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else if (ce) begin
         // a new event beats a clear in the same cycle
         status <= (status & ~(clr_we ? clr_bits : '0)) | event_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable <= '0;
      end else if (ce && en_we) begin
         enable <= en_bits;
      end
   end

   assign irq = |(status & enable);
endmodule : csq_irq

// *** verilog/csq_fetch_dma.sv ***
`include "csq_defines.svh"
module csq_fetch_dma #(
   parameter int BEAT_W = `CSQ_BEAT_W,
   parameter int BURST_LEN = `CSQ_BURST_LEN,
   parameter int BURSTS = `CSQ_BURSTS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic start,
   input wire logic [31:0] base_addr,
   output logic busy,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [4:0] mem_len,
   input wire logic mem_gnt,
   input wire logic mem_rvalid,
   input wire logic [BEAT_W-1:0] mem_rdata,
   output logic instr_valid,
   output logic [2*BEAT_W-1:0] instr_data
);
   localparam int BT_W = $clog2(BURST_LEN);
   localparam int BU_W = $clog2(BURSTS + 1);
   localparam logic [31:0] BURST_BYTES = 32'(BURST_LEN * BEAT_W / 8);

   csq_pkg::csq_dma_state_e state;
   logic [BT_W-1:0] beat_cnt;
   logic [BU_W-1:0] burst_cnt;
   logic [BEAT_W-1:0] low_beat;

   assign busy = (state != csq_pkg::CSQ_DMA_IDLE);
   assign mem_len = 5'(BURST_LEN);

   // the whole group is always fetched, whatever the commands hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= csq_pkg::CSQ_DMA_IDLE;
         mem_req <= 1'b0;
         mem_addr <= 32'h0000_0000;
         beat_cnt <= '0;
         burst_cnt <= '0;
      end else if (ce) begin
         case (state)
            csq_pkg::CSQ_DMA_IDLE: begin
               if (start) begin
                  mem_addr <= base_addr;
                  mem_req <= 1'b1;
                  beat_cnt <= '0;
                  burst_cnt <= '0;
                  state <= csq_pkg::CSQ_DMA_REQ;
               end
            end
            csq_pkg::CSQ_DMA_REQ: begin
               if (mem_gnt) begin
                  mem_req <= 1'b0;
                  state <= csq_pkg::CSQ_DMA_DATA;
               end
            end
            csq_pkg::CSQ_DMA_DATA: begin
               if (mem_rvalid) begin
                  beat_cnt <= beat_cnt + 1'b1;
                  if (beat_cnt == BT_W'(BURST_LEN - 1)) begin
                     if (burst_cnt == BU_W'(BURSTS - 1)) begin
                        state <= csq_pkg::CSQ_DMA_IDLE;
                     end else begin
                        burst_cnt <= burst_cnt + 1'b1;
                        mem_addr <= mem_addr + BURST_BYTES;
                        mem_req <= 1'b1;
                        state <= csq_pkg::CSQ_DMA_REQ;
                     end
                  end
               end
            end
            default: state <= csq_pkg::CSQ_DMA_IDLE;
         endcase
      end
   end

   // two beats, low half first, make one instruction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_beat <= '0;
         instr_valid <= 1'b0;
         instr_data <= '0;
      end else if (ce) begin
         instr_valid <= 1'b0;
         if (state == csq_pkg::CSQ_DMA_DATA && mem_rvalid) begin
            if (!beat_cnt[0]) begin
               low_beat <= mem_rdata;
            end else begin
               instr_data <= {mem_rdata, low_beat};
               instr_valid <= 1'b1;
            end
         end
      end
   end
endmodule : csq_fetch_dma

// *** verilog/csq_stop_ctrl.sv ***
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "csq_defines.svh"
module csq_stop_ctrl #(
   parameter int ADDR_W = 8,
   parameter int WORK_N = 4,
   parameter int BEAT_W = `CSQ_BEAT_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [4:0] mem_len,
   input wire logic mem_gnt,
   input wire logic mem_rvalid,
   input wire logic [BEAT_W-1:0] mem_rdata,
   output logic irq,
   output logic soft_reset,
   output logic fetch_active
);
   localparam int WI_W = $clog2(WORK_N);
   localparam logic [ADDR_W-1:0] WORK_END =
      ADDR_W'(`CSQ_OFF_WORK + 4 * WORK_N);

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_mask

   function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`CSQ_OFF_MODE)) begin
         decode = `CSQ_SEL_MODE;
      end else if (a == ADDR_W'(`CSQ_OFF_PROG_BASE)) begin
         decode = `CSQ_SEL_PROG_BASE;
      end else if (a == ADDR_W'(`CSQ_OFF_STATUS0)) begin
         decode = `CSQ_SEL_STATUS0;
      end else if (a == ADDR_W'(`CSQ_OFF_STATUS3)) begin
         decode = `CSQ_SEL_STATUS3;
      end else if (a == ADDR_W'(`CSQ_OFF_IRQ_STATUS)) begin
         decode = `CSQ_SEL_IRQ_STATUS;
      end else if (a == ADDR_W'(`CSQ_OFF_IRQ_ENABLE)) begin
         decode = `CSQ_SEL_IRQ_ENABLE;
      end else if (a == ADDR_W'(`CSQ_OFF_IRQ_CLEAR)) begin
         decode = `CSQ_SEL_IRQ_CLEAR;
      end else if (a >= ADDR_W'(`CSQ_OFF_WORK) && a < WORK_END &&
                   a[1:0] == 2'b00) begin
         decode = `CSQ_SEL_WORK;
      end else begin
         decode = `CSQ_SEL_NONE;
      end
   endfunction : decode

   csq_pkg::csq_state_e state;
   csq_pkg::csq_state_e next_state;

   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic rvalid_q;
   logic do_write;
   logic [3:0] wr_sel;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [3:0] rd_sel;
   logic [31:0] next_rdata;

   logic run_go;
   logic stop_req;
   logic ahalt_req;
   logic [31:0] prog_base;
   logic [31:0] fetch_addr;
   logic dma_start;
   logic dma_busy;
   logic next_dma_start;
   logic sr_pending;
   logic stop_seen;
   logic ahalt_seen;
   logic [1:0] st0_clr;
   logic [15:0] cmd_count;
   logic [31:0] work [WORK_N];

   logic instr_valid;
   logic [2*BEAT_W-1:0] instr_data;
   logic [3:0] opcode;
   logic exec_ok;
   logic stop_cmd;
   logic work_cmd;
   logic [WI_W-1:0] cmd_idx;

   logic [1:0] irq_status;
   logic [1:0] irq_enable;

   // ---- axi4-lite slave ----
   // readies drop with ce so that no handshake is taken while frozen
   assign awready = ce & ~aw_held & ~bvalid_q;
   assign wready = ce & ~w_held & ~bvalid_q;
   assign arready = ce & ~rvalid_q;
   assign bvalid = bvalid_q & ce;
   assign rvalid = rvalid_q & ce;
   assign do_write = aw_held & w_held & ~bvalid_q;
   assign wr_sel = decode(aw_addr_q);
   assign wmask = strb_mask(w_strb_q);
   assign wval = w_data_q & wmask;
   assign rd_sel = decode(araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr_q <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // the response does not look at soft reset, so it always comes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp <= `CSQ_RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp <= (wr_sel == `CSQ_SEL_NONE) ?
                     `CSQ_RESP_SLVERR : `CSQ_RESP_OKAY;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd_sel == `CSQ_SEL_PROG_BASE) begin
         next_rdata = prog_base;
      end else if (rd_sel == `CSQ_SEL_STATUS0) begin
         next_rdata[`CSQ_ST0_STOP_SEEN] = stop_seen;
         next_rdata[`CSQ_ST0_AHALT_SEEN] = ahalt_seen;
         next_rdata[`CSQ_ST0_STATE_LSB +: 2] = state;
      end else if (rd_sel == `CSQ_SEL_STATUS3) begin
         next_rdata[`CSQ_ST3_FETCH_ON] = fetch_active;
         next_rdata[`CSQ_ST3_SR_PEND] = sr_pending;
         next_rdata[`CSQ_ST3_COUNT_LSB +: 16] = cmd_count;
      end else if (rd_sel == `CSQ_SEL_IRQ_STATUS) begin
         next_rdata[1:0] = irq_status;
      end else if (rd_sel == `CSQ_SEL_IRQ_ENABLE) begin
         next_rdata[1:0] = irq_enable;
      end else if (rd_sel == `CSQ_SEL_WORK) begin
         next_rdata = work[araddr[2 +: WI_W]];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `CSQ_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata <= next_rdata;
            rresp <= (rd_sel == `CSQ_SEL_NONE) ?
                     `CSQ_RESP_SLVERR : `CSQ_RESP_OKAY;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ---- software control ----
   assign run_go = do_write && wr_sel == `CSQ_SEL_MODE &&
                   wval[`CSQ_MODE_RUN];
   assign stop_req = do_write && wr_sel == `CSQ_SEL_MODE &&
                     wval[`CSQ_MODE_STOP];
   assign ahalt_req = do_write && wr_sel == `CSQ_SEL_MODE &&
                      wval[`CSQ_MODE_AHALT];
   assign st0_clr = (do_write && wr_sel == `CSQ_SEL_STATUS0) ?
                    wval[1:0] : 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_base <= `CSQ_RST_PROG_BASE;
      end else if (ce && do_write && wr_sel == `CSQ_SEL_PROG_BASE) begin
         prog_base <= (prog_base & ~wmask) | wval;
      end
   end

   // ---- command decode ----
   assign opcode = instr_data[`CSQ_OP_LSB +: 4];
   assign cmd_idx = instr_data[`CSQ_IDX_LSB +: WI_W];
   // commands after a stop or halt in the same group are dropped
   assign exec_ok = instr_valid && state == csq_pkg::CSQ_RUN &&
                    !stop_req && !ahalt_req;
   assign stop_cmd = exec_ok && opcode == `CSQ_OP_STOP;
   assign work_cmd = exec_ok && opcode == `CSQ_OP_WORK;

   // ---- sequencer state machine ----
   always_comb begin
      next_state = state;
      case (state)
         csq_pkg::CSQ_START: begin
            // no restart until the previous soft reset has fired
            if (run_go && !sr_pending && !soft_reset) begin
               next_state = csq_pkg::CSQ_RUN;
            end
         end
         csq_pkg::CSQ_RUN: begin
            if (ahalt_req) begin
               next_state = csq_pkg::CSQ_AHALT;
            end else if (stop_req || stop_cmd) begin
               next_state = csq_pkg::CSQ_STOP;
            end
         end
         csq_pkg::CSQ_STOP: next_state = csq_pkg::CSQ_START;
         csq_pkg::CSQ_AHALT: next_state = csq_pkg::CSQ_START;
         default: next_state = csq_pkg::CSQ_START;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= csq_pkg::CSQ_START;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ---- fetch launch ----
   assign next_dma_start =
      (state == csq_pkg::CSQ_START && next_state == csq_pkg::CSQ_RUN) ||
      (state == csq_pkg::CSQ_RUN && next_state == csq_pkg::CSQ_RUN &&
       !dma_busy && !dma_start);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_start <= 1'b0;
         fetch_addr <= 32'h0000_0000;
      end else if (ce) begin
         dma_start <= next_dma_start;
         if (next_dma_start) begin
            fetch_addr <= (state == csq_pkg::CSQ_START) ?
                          prog_base : fetch_addr + `CSQ_GROUP_BYTES;
         end
      end
   end

   assign fetch_active = dma_busy | dma_start;

   csq_fetch_dma #(
      .BEAT_W(BEAT_W),
      .BURST_LEN(`CSQ_BURST_LEN),
      .BURSTS(`CSQ_BURSTS)
   ) u_fetch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .start(dma_start),
      .base_addr(fetch_addr),
      .busy(dma_busy),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_len(mem_len),
      .mem_gnt(mem_gnt),
      .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata),
      .instr_valid(instr_valid),
      .instr_data(instr_data)
   );

   // ---- soft reset ----
   // held back while any fetch is still in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sr_pending <= 1'b0;
         soft_reset <= 1'b0;
      end else if (ce) begin
         soft_reset <= 1'b0;
         if (state == csq_pkg::CSQ_STOP || state == csq_pkg::CSQ_AHALT) begin
            sr_pending <= 1'b1;
         end else if (sr_pending && !dma_busy && !dma_start) begin
            sr_pending <= 1'b0;
            soft_reset <= 1'b1;
         end
      end
   end

   // ---- phase flags ----
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_seen <= 1'b0;
         ahalt_seen <= 1'b0;
      end else if (ce) begin
         stop_seen <= (stop_seen & ~st0_clr[`CSQ_ST0_STOP_SEEN]) |
                      (state == csq_pkg::CSQ_STOP);
         ahalt_seen <= (ahalt_seen & ~st0_clr[`CSQ_ST0_AHALT_SEEN]) |
                       (state == csq_pkg::CSQ_AHALT);
      end
   end

   csq_irq #(
      .N(2)
   ) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .event_set({state == csq_pkg::CSQ_AHALT,
                  state == csq_pkg::CSQ_STOP}),
      .clr_we(do_write && wr_sel == `CSQ_SEL_IRQ_CLEAR),
      .clr_bits(wval[1:0]),
      .en_we(do_write && wr_sel == `CSQ_SEL_IRQ_ENABLE),
      .en_bits(wval[1:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

   // ---- executed command count ----
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_count <= 16'h0000;
      end else if (ce) begin
         if (soft_reset) begin
            cmd_count <= 16'h0000;
         end else if (exec_ok) begin
            cmd_count <= cmd_count + 16'h0001;
         end
      end
   end

   // ---- work registers ----
   // soft reset wins the data, but the bus access still completes
   for (genvar i = 0; i < WORK_N; i++) begin : g_work
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            work[i] <= `CSQ_RST_WORK;
         end else if (ce) begin
            if (soft_reset) begin
               work[i] <= `CSQ_RST_WORK;
            end else if (work_cmd && cmd_idx == WI_W'(i)) begin
               work[i] <= instr_data[31:0];
            end else if (do_write && wr_sel == `CSQ_SEL_WORK &&
                         aw_addr_q[2 +: WI_W] == WI_W'(i)) begin
               work[i] <= (work[i] & ~wmask) | wval;
            end
         end
      end
   end
endmodule : csq_stop_ctrl

// *** tb/csq_stop_ctrl_assertions.sv ***
module csq_stop_ctrl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic mem_req,
   input wire logic [4:0] mem_len,
   input wire logic mem_gnt,
   input wire logic soft_reset,
   input wire logic fetch_active
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_req_wait;
      mem_req && !mem_gnt;
   endsequence

   property p_wr_answer;
      s_wr_taken |-> ##2 bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_rd_answer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read data late");
   property p_b_hold;
      bvalid && !bready |=> bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_r_hold;
      rvalid && !rready |=> rvalid;
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   property p_sr_pulse;
      $rose(soft_reset) |=> !soft_reset;
   endproperty
   a_sr_pulse: assert property (p_sr_pulse)
      else $error("soft reset too long");
   // a pulse while a fetch is still in flight is the hang hazard
   property p_sr_idle;
      soft_reset |-> !mem_req && !fetch_active;
   endproperty
   a_sr_idle: assert property (p_sr_idle)
      else $error("soft reset while fetch active");
   property p_req_hold;
      s_req_wait |=> mem_req;
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request dropped");
   property p_len;
      mem_req |-> mem_len == 5'h10;
   endproperty
   a_len: assert property (p_len)
      else $error("burst length not sixteen");
   property p_fetch_flag;
      mem_req |-> fetch_active;
   endproperty
   a_fetch_flag: assert property (p_fetch_flag)
      else $error("fetch flag low during request");
endmodule : csq_stop_ctrl_chk

bind csq_stop_ctrl csq_stop_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .mem_req(mem_req), .mem_len(mem_len),
   .mem_gnt(mem_gnt), .soft_reset(soft_reset), .fetch_active(fetch_active));

// *** tb/csq_mem_model.sv ***
module csq_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_gnt,
   output logic mem_rvalid,
   output logic [63:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] prog [0:127];
   logic [31:0] ptr;
   logic go;
   int left;
   int bursts;
   int seed = 16;
   // slow mode stalls grants and beats at random like a busy crossbar
   always @(posedge aclk) begin
      go = !slow || $random(seed) & 1;
      if (!aresetn) begin
         mem_gnt <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 64'h0;
         left <= 0;
         bursts <= 0;
      end else begin
         mem_gnt <= mem_req && !mem_gnt && left == 0 && go;
         mem_rvalid <= left > 0 && go;
         // idle data toggles so a stale beat never looks right
         mem_rdata <= ~mem_rdata;
         if (mem_req && mem_gnt) begin
            ptr <= mem_addr;
            left <= 16;
            bursts <= bursts + 1;
         end else if (left > 0 && go) begin
            mem_rdata <= prog[ptr[9:3]];
            ptr <= ptr + 32'h8;
            left <= left - 1;
         end
      end
   end
endmodule : csq_mem_model

// *** tb/tb_csq_stop_ctrl.sv ***
`include "csq_defines.svh"
module tb_csq_stop_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, ce = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, mem_addr;
   logic awready, wready, bvalid, arready, rvalid, mem_req, mem_gnt;
   logic mem_rvalid, irq, soft_reset, fetch_active;
   logic [1:0] bresp, rresp;
   logic [4:0] mem_len;
   logic [3:0] wstrb = 4'hf;
   logic [63:0] mem_rdata;
   int seed = 15;
   int fail_count = 0;
   int checked = 0;
   int sr_count = 0;

   csq_stop_ctrl #(.ADDR_W(8), .WORK_N(4), .BEAT_W(64)) u_csq_stop_ctrl (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
      .awprot(3'b000), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'b000),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_len(mem_len), .mem_gnt(mem_gnt),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .irq(irq),
      .soft_reset(soft_reset), .fetch_active(fetch_active));
   csq_mem_model u_csq_mem_model (.aclk(aclk), .aresetn(aresetn),
      .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   initial begin
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (soft_reset === 1'b1)
         sr_count <= sr_count + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // readies are sampled mid-cycle, then acted on at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic pa = 1'b1, pw = 1'b1, ta, tw;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         if (bvalid === 1'b1)
            chk(bresp, er);
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            return;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      logic pa = 1'b1, ta, got;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = pa && arready;
         got = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) begin
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         if (got) begin
            rready <= 1'b0;
            return;
         end
      end
   endtask : rd
   function automatic int flag_bit(input int k);
      return (k == 2) ? 1 : 0;
   endfunction : flag_bit
   task automatic conclude;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   initial begin
      repeat (50000) @(posedge aclk);
      fail_count++;
      conclude();
   end
   initial begin
      logic [31:0] d, s, v, base;
      logic [1:0] r;
      int n, fb, b0, c0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CSQ_OFF_STATUS0, d, r);
      chk(d, 32'h0);
      v = $random(seed);
      wr(8'h40, v, `CSQ_RESP_SLVERR);
      rd(8'h40, d, r);
      chk({r, d[29:0]}, {`CSQ_RESP_SLVERR, 30'h0});
      wstrb <= v[3:0];
      wr(`CSQ_OFF_WORK, v, `CSQ_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`CSQ_OFF_WORK, d, r);
      chk(d, v & {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}});
      // stop by command, by software stop, by async halt
      for (int k = 0; k < 3; k++) begin
         v = $random(seed);
         base = $random(seed) & 32'h300;
         slow <= v[31];
         fb = flag_bit(k);
         for (n = 0; n < 128; n++)
            u_csq_mem_model.prog[n] = 64'h0;
         u_csq_mem_model.prog[base[9:3]] = {32'h0, v};
         u_csq_mem_model.prog[base[9:3] + 1] = {4'h1, 58'h0, 2'd1};
         if (k == 0)
            u_csq_mem_model.prog[base[9:3] + 3] = {4'hf, 60'h0};
         b0 = u_csq_mem_model.bursts;
         c0 = sr_count;
         wr(`CSQ_OFF_PROG_BASE, base, `CSQ_RESP_OKAY);
         wr(`CSQ_OFF_IRQ_ENABLE, 32'h3, `CSQ_RESP_OKAY);
         wr(`CSQ_OFF_MODE, 32'h1, `CSQ_RESP_OKAY);
         if (k > 0) begin
            repeat (40) @(posedge aclk);
            wr(`CSQ_OFF_MODE, 32'h1 << k, `CSQ_RESP_OKAY);
         end
         d = 32'h0;
         for (n = 0; n < 200 && d[fb] !== 1'b1; n++)
            rd(`CSQ_OFF_STATUS0, d, r);
         chk(d[fb], 1'b1);
         @(negedge aclk);
         chk(irq, 1'b1);
         n = 0;
         // hammer work registers across the soft reset window
         do begin
            rd(`CSQ_OFF_WORK + 8'h4, d, r);
            chk(r, `CSQ_RESP_OKAY);
            rd(`CSQ_OFF_STATUS3, s, r);
            n++;
         end while (s[1:0] !== 2'b00 && n < 100);
         chk(s[1:0], 2'b00);
         @(negedge aclk);
         chk(fetch_active, 1'b0);
         chk(sr_count - c0, 1);
         n = u_csq_mem_model.bursts - b0;
         chk(n % 2, 0);
         if (k == 0)
            chk(n, 2);
         rd(`CSQ_OFF_WORK + 8'h4, d, r);
         chk(d, 32'h0);
         rd(`CSQ_OFF_STATUS0, d, r);
         chk(d[3:2], 2'b00);
         wr(`CSQ_OFF_STATUS0, 32'h1 << fb, `CSQ_RESP_OKAY);
         rd(`CSQ_OFF_STATUS0, d, r);
         chk(d[1:0], 2'b00);
         wr(`CSQ_OFF_IRQ_CLEAR, 32'h3, `CSQ_RESP_OKAY);
         @(negedge aclk);
         chk(irq, 1'b0);
         $display("test %0d done", k);
      end
      conclude();
   end
endmodule : tb_csq_stop_ctrl
